/* File: common/vec_pack_pkg.sv */
package vec_pack_pkg;

	// Register byte offsets on the AXI4-Lite port.
	localparam logic [3:0] CTRL_OFS    = 4'h0;
	localparam logic [3:0] STATUS_OFS  = 4'h4;
	localparam logic [3:0] VEC_CNT_OFS = 4'h8;
	localparam logic [3:0] ERR_CNT_OFS = 4'hc;
	localparam logic       CTRL_EN_RST = 1'b1;
	localparam int         CTRL_EN_BIT = 0;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Vector kinds as offered by the decoder.
	localparam logic [1:0] KIND_SECURE = 2'h0;
	localparam logic [1:0] KIND_ALPHA  = 2'h1;
	localparam logic [1:0] KIND_HEX    = 2'h2;
	localparam logic [1:0] KIND_INSTR  = 2'h3;

	// Vector type codes placed in byte 2 bits 2 to 0.
	localparam logic [2:0] VT_SECURE = 3'h0;
	localparam logic [2:0] VT_ALPHA  = 3'h5;
	localparam logic [2:0] VT_HEX    = 3'h6;
	localparam logic [2:0] VT_INSTR  = 3'h1;

	// Instruction types.
	localparam logic [2:0] IT_TADDR     = 3'h0;
	localparam logic [2:0] IT_EVENTS    = 3'h1;
	localparam logic [2:0] IT_TADDR_SEQ = 3'h2;

	// Field positions inside a packet word.
	localparam int ERR_BIT  = 23;
	localparam int PH_LSB   = 21;
	localparam int VT_LSB   = 16;
	localparam int WN_LSB   = 24;

	// Validity ranges and error threshold.
	localparam logic [6:0] WN_MIN    = 7'h02;
	localparam logic [6:0] WN_MAX    = 7'h57;
	localparam logic [6:0] CNT_MIN   = 7'h01;
	localparam logic [6:0] CNT_MAX   = 7'h55;
	localparam logic [6:0] START_MIN = 7'h03;
	localparam logic [6:0] START_MAX = 7'h57;
	localparam logic [2:0] ERR_LIMIT = 3'h2;

endpackage

/* File: common/vec_pack_if.sv */
`timescale 1ns/100ps
interface vec_pack_if;
	logic [1:0]  kind;
	logic [6:0]  wn;
	logic [1:0]  phase;
	logic [2:0]  bit_errs;
	logic        check_fail;
	logic [6:0]  count;
	logic [6:0]  start;
	logic [2:0]  itype;
	logic [3:0]  taddr;
	logic [6:0]  frame;
	logic [5:0]  message_sequence_number;
	logic [10:0] events;
	logic [6:0]  msg_wn;
	logic [1:0]  msg_phase;
	logic [2:0]  msg_bit_errs;
	logic [20:0] msg_info;
	logic [31:0] vec_word;
	logic        vec_err;
	logic [31:0] msg_word;

	modport owner (output kind, wn, phase, bit_errs, check_fail, count, start, itype,
		taddr, frame, message_sequence_number, events, msg_wn, msg_phase, msg_bit_errs,
		msg_info, input vec_word, vec_err, msg_word);
	modport packer (input kind, wn, phase, bit_errs, check_fail, count, start, itype,
		taddr, frame, message_sequence_number, events, msg_wn, msg_phase, msg_bit_errs,
		msg_info, output vec_word, vec_err, msg_word);
endinterface

/* File: rtl/vec_word_packer.sv */
`timescale 1ns/100ps
module vec_word_packer
(
	// Fields in, packed words out.
	vec_pack_if.packer pk
);
	function automatic logic in_range(input logic [6:0] v, input logic [6:0] lo,
		input logic [6:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	logic        is_instr;
	logic        bad_value;
	logic [2:0]  vtype;
	logic [10:0] data;
	logic [15:0] low_half;

	assign is_instr = (pk.kind == vec_pack_pkg::KIND_INSTR);

	// For vectors other than instructions, a word position, count or start outside its legal range marks the vector invalid.
	assign bad_value = !in_range(pk.wn, vec_pack_pkg::WN_MIN, vec_pack_pkg::WN_MAX) ||
		(!is_instr && (!in_range(pk.count, vec_pack_pkg::CNT_MIN, vec_pack_pkg::CNT_MAX) ||
		!in_range(pk.start, vec_pack_pkg::START_MIN, vec_pack_pkg::START_MAX)));

	always_comb
	begin
		unique case (pk.kind)
			vec_pack_pkg::KIND_SECURE: vtype = vec_pack_pkg::VT_SECURE;
			vec_pack_pkg::KIND_ALPHA:  vtype = vec_pack_pkg::VT_ALPHA;
			vec_pack_pkg::KIND_HEX:    vtype = vec_pack_pkg::VT_HEX;
			vec_pack_pkg::KIND_INSTR:  vtype = vec_pack_pkg::VT_INSTR;
		endcase
	end

	always_comb
	begin
		case (pk.itype)
			vec_pack_pkg::IT_TADDR:     data = {pk.taddr, pk.frame};
			vec_pack_pkg::IT_TADDR_SEQ: data = {pk.taddr, pk.frame[6],
				pk.message_sequence_number};
			default:                    data = pk.events;
		endcase
	end

	always_comb
	begin
		if (is_instr)
		begin
			pk.vec_err = (pk.bit_errs > vec_pack_pkg::ERR_LIMIT) || pk.check_fail;
			low_half   = {2'h0, data, pk.itype};
		end
		else
		begin
			pk.vec_err = (pk.bit_errs > vec_pack_pkg::ERR_LIMIT) || pk.check_fail ||
				bad_value;
			low_half   = {2'h0, pk.count, pk.start};
		end
	end

	// Unused bits are driven as zero so a packet never depends on stale state.
	assign pk.vec_word = {1'b0, pk.wn, pk.vec_err, pk.phase, 2'h0, vtype, low_half};
	assign pk.msg_word = {1'b0, pk.msg_wn, pk.msg_bit_errs > vec_pack_pkg::ERR_LIMIT,
		pk.msg_phase, pk.msg_info};
endmodule

/* File: rtl/vec_packet_framer.sv */
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module vec_packet_framer
(
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Vector from the decoder.
	input  wire logic        vec_valid,
	output      logic        vec_ready,
	input  wire logic [1:0]  vec_kind,
	input  wire logic [6:0]  vec_frame_word_index,
	input  wire logic [1:0]  vec_phase,
	input  wire logic [2:0]  vec_bit_errs,
	input  wire logic        vec_check_fail,
	input  wire logic        vec_long,
	input  wire logic [6:0]  vec_count,
	input  wire logic [6:0]  vec_start,
	input  wire logic [2:0]  vec_itype,
	input  wire logic [3:0]  vec_taddr,
	input  wire logic [6:0]  vec_frame,
	input  wire logic [5:0]  vec_message_sequence_number,
	input  wire logic [10:0] vec_events,
	// Message words from the decoder.
	input  wire logic        msg_valid,
	output      logic        msg_ready,
	input  wire logic [1:0]  msg_phase,
	input  wire logic [2:0]  msg_bit_errs,
	input  wire logic [20:0] msg_info,
	// Packets to the host.
	output      logic        pkt_valid,
	input  wire logic        pkt_ready,
	output      logic [31:0] pkt_data,
	// AXI4-Lite slave.
	input  wire logic        awvalid,
	output      logic        awready,
	input  wire logic [3:0]  awaddr,
	input  wire logic        wvalid,
	output      logic        wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output      logic        bvalid,
	input  wire logic        bready,
	output      logic [1:0]  bresp,
	input  wire logic        arvalid,
	output      logic        arready,
	input  wire logic [3:0]  araddr,
	output      logic        rvalid,
	input  wire logic        rready,
	output      logic [31:0] rdata,
	output      logic [1:0]  rresp
);
	typedef enum logic [2:0] {IDLE, VEC_LOAD, VEC_WAIT, MSG_TAKE, MSG_LOAD, MSG_WAIT} state_type;

	state_type   state_r;
	vec_pack_if  pk ();
	logic        vec_ready_r, msg_ready_r, pkt_valid_r, long_r, err_r, first_msg_r, vchk_r;
	logic        enable_r, aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r;
	logic        rvalid_r, vec_take, msg_take, pkt_take;
	logic [1:0]  kind_r, vph_r, mph_r, bresp_r, rresp_r;
	logic [2:0]  verr_r, itype_r, merr_r;
	logic [3:0]  taddr_r, awaddr_r, wstrb_r;
	logic [5:0]  seq_r;
	logic [6:0]  remaining_r, next_wn_r, vwn_r, cnt_r, start_r, frame_r, mwn_r;
	logic [10:0] events_r;
	logic [20:0] minfo_r;
	logic [31:0] pkt_data_r, vec_cnt_r, err_cnt_r, wdata_r, rdata_r;

	assign vec_take = vec_valid && vec_ready_r;
	assign msg_take = msg_valid && msg_ready_r;
	assign pkt_take = pkt_valid_r && pkt_ready;

	assign {pk.kind, pk.wn, pk.phase, pk.bit_errs} = {kind_r, vwn_r, vph_r, verr_r};
	assign {pk.check_fail, pk.count, pk.start, pk.itype} = {vchk_r, cnt_r, start_r, itype_r};
	assign {pk.taddr, pk.frame, pk.message_sequence_number} = {taddr_r, frame_r, seq_r};
	assign {pk.events, pk.msg_wn, pk.msg_phase} = {events_r, mwn_r, mph_r};
	assign {pk.msg_bit_errs, pk.msg_info} = {merr_r, minfo_r};

	vec_word_packer u_packer (.pk(pk));

	// Vector fields are captured so the packet cannot change while the host reads it.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			{kind_r, vwn_r, vph_r, verr_r, vchk_r, long_r} <= '0;
			{cnt_r, start_r, itype_r, taddr_r, frame_r, seq_r, events_r} <= '0;
		end
		else if (vec_take)
		begin
			{kind_r, vwn_r, vph_r} <= {vec_kind, vec_frame_word_index, vec_phase};
			{verr_r, vchk_r, long_r} <= {vec_bit_errs, vec_check_fail, vec_long};
			{cnt_r, start_r, itype_r} <= {vec_count, vec_start, vec_itype};
			{taddr_r, frame_r, seq_r} <= {vec_taddr, vec_frame, vec_message_sequence_number};
			events_r <= vec_events;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			{mph_r, merr_r, minfo_r, mwn_r} <= '0;
		else if (msg_take)
		begin
			{mph_r, merr_r, minfo_r} <= {msg_phase, msg_bit_errs, msg_info};
			mwn_r <= next_wn_r;
		end
	end

	// Sequencer: vector packet, then its message packets.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= IDLE;
			{vec_ready_r, msg_ready_r, pkt_valid_r, err_r, first_msg_r} <= '0;
			{pkt_data_r, remaining_r, next_wn_r} <= '0;
		end
		else
		begin
			unique case (state_r)
				IDLE:
				begin
					vec_ready_r <= enable_r && !vec_take;
					if (vec_take)
						state_r <= VEC_LOAD;
				end
				VEC_LOAD:
				begin
					pkt_data_r  <= pk.vec_word;
					pkt_valid_r <= 1'b1;
					err_r       <= pk.vec_err;
					first_msg_r <= long_r;
					next_wn_r   <= long_r ? 7'(vwn_r + 7'h01) : start_r;
					if (pk.vec_err)
						remaining_r <= '0;
					else if (kind_r == vec_pack_pkg::KIND_INSTR)
						remaining_r <= {6'h00, long_r};
					else
						remaining_r <= cnt_r;
					state_r <= VEC_WAIT;
				end
				VEC_WAIT, MSG_WAIT:
					if (pkt_take)
					begin
						pkt_valid_r <= 1'b0;
						if (remaining_r == 7'h00)
							state_r <= IDLE;
						else
						begin
							msg_ready_r <= 1'b1;
							state_r     <= MSG_TAKE;
						end
					end
				MSG_TAKE:
					if (msg_take)
					begin
						msg_ready_r <= 1'b0;
						remaining_r <= 7'(remaining_r - 7'h01);
						first_msg_r <= 1'b0;
						next_wn_r   <= first_msg_r ? start_r : 7'(next_wn_r + 7'h01);
						state_r     <= MSG_LOAD;
					end
				MSG_LOAD:
				begin
					pkt_data_r  <= pk.msg_word;
					pkt_valid_r <= 1'b1;
					state_r     <= MSG_WAIT;
				end
			endcase
		end
	end

	// Event counters seen by software; they wrap rather than saturate.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			{vec_cnt_r, err_cnt_r} <= '0;
		else if (state_r == VEC_LOAD)
		begin
			vec_cnt_r <= vec_cnt_r + 32'h1;
			if (pk.vec_err)
				err_cnt_r <= err_cnt_r + 32'h1;
		end
	end

	// Write channel: address and data taken in either order.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			{aw_got_r, w_got_r, awready_r, wready_r, bvalid_r} <= '0;
			{awaddr_r, wdata_r, wstrb_r, bresp_r} <= '0;
			enable_r <= vec_pack_pkg::CTRL_EN_RST;
		end
		else
		begin
			awready_r <= !aw_got_r && !(awvalid && awready_r) && !bvalid_r;
			wready_r  <= !w_got_r && !(wvalid && wready_r) && !bvalid_r;
			if (awvalid && awready_r)
			begin
				aw_got_r <= 1'b1;
				awaddr_r <= awaddr;
			end
			if (wvalid && wready_r)
			begin
				w_got_r <= 1'b1;
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			if (aw_got_r && w_got_r && !bvalid_r)
			begin
				{aw_got_r, w_got_r, bvalid_r} <= 3'h1;
				bresp_r <= vec_pack_pkg::RESP_OKAY;
				unique case (awaddr_r)
					vec_pack_pkg::CTRL_OFS:
						if (wstrb_r[0])
							enable_r <= wdata_r[vec_pack_pkg::CTRL_EN_BIT];
					vec_pack_pkg::STATUS_OFS, vec_pack_pkg::VEC_CNT_OFS,
					vec_pack_pkg::ERR_CNT_OFS: ;
					default: bresp_r <= vec_pack_pkg::RESP_DECERR;
				endcase
			end
			else if (bvalid_r && bready)
				bvalid_r <= 1'b0;
		end
	end

	// Read channel.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			{arready_r, rvalid_r, rdata_r, rresp_r} <= '0;
		else
		begin
			arready_r <= !rvalid_r && !(arvalid && arready_r);
			if (arvalid && arready_r)
			begin
				rvalid_r <= 1'b1;
				rresp_r  <= vec_pack_pkg::RESP_OKAY;
				unique case (araddr)
					vec_pack_pkg::CTRL_OFS:    rdata_r <= {31'h0, enable_r};
					vec_pack_pkg::STATUS_OFS:  rdata_r <= {20'h0, remaining_r, err_r,
						1'b0, 3'(state_r)};
					vec_pack_pkg::VEC_CNT_OFS: rdata_r <= vec_cnt_r;
					vec_pack_pkg::ERR_CNT_OFS: rdata_r <= err_cnt_r;
					default:
					begin
						rdata_r <= '0;
						rresp_r <= vec_pack_pkg::RESP_DECERR;
					end
				endcase
			end
			else if (rvalid_r && rready)
				rvalid_r <= 1'b0;
		end
	end

	assign vec_ready = vec_ready_r;
	assign msg_ready = msg_ready_r;
	assign pkt_valid = pkt_valid_r;
	assign pkt_data  = pkt_data_r;
	assign awready   = awready_r;
	assign wready    = wready_r;
	assign bvalid    = bvalid_r;
	assign bresp     = bresp_r;
	assign arready   = arready_r;
	assign rvalid    = rvalid_r;
	assign rdata     = rdata_r;
	assign rresp     = rresp_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_vec_in;
		vec_take ##1 (state_r == VEC_LOAD);
	endsequence

	a_top_bit_zero: assert property (
		s_vec_in |=> pkt_valid_r && !pkt_data_r[31] && pkt_data_r[30:24] == $past(vwn_r))
		else $error("vector packet top byte wrong");
	a_secure_code: assert property (
		s_vec_in ##0 (kind_r == vec_pack_pkg::KIND_SECURE) |=> pkt_data_r[18:16] == 3'h0)
		else $error("secure type code wrong");
	a_error_flag: assert property (
		(state_r == VEC_LOAD) && (verr_r > 3'h2) |=> pkt_data_r[vec_pack_pkg::ERR_BIT])
		else $error("error flag not set on bit errors");
	a_instr_check: assert property (
		(state_r == VEC_LOAD) && kind_r == vec_pack_pkg::KIND_INSTR && vchk_r
		|=> pkt_data_r[23] && pkt_data_r[18:16] == 3'h1)
		else $error("instruction error or type code wrong");
	a_phase_field: assert property (
		(state_r == VEC_LOAD) |=> pkt_data_r[22:21] == $past(vph_r))
		else $error("phase field wrong");
	a_count_start: assert property (
		(state_r == VEC_LOAD) && kind_r != vec_pack_pkg::KIND_INSTR
		|=> pkt_data_r[13:7] == $past(cnt_r) && pkt_data_r[6:0] == $past(start_r))
		else $error("count or start field misplaced");
	a_long_first_wn: assert property (
		(state_r == MSG_TAKE) && msg_take && first_msg_r ##1 (state_r == MSG_LOAD)
		|=> pkt_data_r[30:24] == 7'(vwn_r + 7'h01))
		else $error("first long message word position wrong");
	a_err_withhold: assert property (
		(state_r == VEC_WAIT) && err_r |-> !msg_ready_r ##1 !msg_ready_r)
		else $error("message words taken after errored vector");
	a_instr_follow: assert property (
		s_vec_in ##0 (kind_r == vec_pack_pkg::KIND_INSTR && long_r && !pk.vec_err)
		|=> remaining_r == 7'h01)
		else $error("no message after clean long instruction vector");
	a_pkt_hold: assert property (
		pkt_valid_r && !pkt_ready |=> pkt_valid_r && $stable(pkt_data_r))
		else $error("packet changed before host took it");
endmodule

/* File: verification/host_reader.sv */
`timescale 1ns/100ps
module host_reader
(
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Pace set by the bench.
	input  wire logic        slow,
	// Packet port of the framer.
	input  wire logic        pkt_valid,
	output      logic        pkt_ready,
	input  wire logic [31:0] pkt_data,
	// Packets handed to the bench.
	output      logic        got,
	output      logic [31:0] got_data
);
	logic [1:0] pace_r;

	// A slow host reads only every third cycle, so the framer has to hold its word.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			pace_r <= 2'h0;
		else
			pace_r <= (pace_r == 2'h2) ? 2'h0 : pace_r + 2'h1;
	end

	assign pkt_ready = !rst && (!slow || pace_r == 2'h0);

	// The word is taken whole in one cycle; fields are judged only afterwards.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			got <= 1'b0;
		else
			got <= pkt_valid && pkt_ready;
	end

	always_ff @(posedge sys_clk)
	begin
		got_data <= pkt_data; // Unused bits travel along; the host gives them no meaning.
	end
endmodule

/* File: verification/tb.sv */
`timescale 1ns/100ps
module tb;
	localparam logic [1:0] SEC = vec_pack_pkg::KIND_SECURE;
	localparam logic [1:0] ALP = vec_pack_pkg::KIND_ALPHA;
	localparam logic [1:0] HEX = vec_pack_pkg::KIND_HEX;
	localparam logic [1:0] INS = vec_pack_pkg::KIND_INSTR;
	logic        sys_clk;
	logic        rst;
	logic        slow;
	logic        vec_valid;
	logic        vec_ready;
	logic [29:0] vin;
	logic        msg_valid;
	logic        msg_ready;
	logic [25:0] min;
	logic        pkt_valid;
	logic        pkt_ready;
	logic [31:0] pkt_data;
	logic        got;
	logic [31:0] got_data;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [31:0] rx_q[$];
	int          err_count;
	int          compares;
	int          nv;
	int          ne;

	vec_packet_framer i_dut (.sys_clk, .rst, .vec_valid, .vec_ready, .vec_kind(vin[29:28]),
		.vec_frame_word_index(vin[27:21]), .vec_phase(vin[20:19]), .vec_bit_errs(vin[18:16]),
		.vec_check_fail(vin[15]), .vec_long(vin[14]), .vec_count(vin[13:7]),
		.vec_start(vin[6:0]), .vec_itype(vin[2:0]), .vec_taddr(vin[13:10]),
		.vec_frame(vin[9:3]), .vec_message_sequence_number(vin[8:3]), .vec_events(vin[13:3]),
		.msg_valid, .msg_ready, .msg_phase(min[25:24]), .msg_bit_errs(min[23:21]),
		.msg_info(min[20:0]), .pkt_valid, .pkt_ready, .pkt_data, .awvalid, .awready, .awaddr,
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .rvalid, .rready, .rdata, .rresp);

	host_reader i_host (.sys_clk, .rst, .slow, .pkt_valid, .pkt_ready, .pkt_data, .got,
		.got_data);

	always #50 sys_clk = ~sys_clk;

	always @(posedge sys_clk)
		if (got)
			rx_q.push_back(got_data);

	task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task test_done;
		$display("compares %0d, err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task pop_chk(input string what, input logic [31:0] exp, input logic [31:0] mask);
		int          t;
		logic [31:0] w;
		t = 0;
		do
		begin
			@(posedge sys_clk);
			t++;
		end
		while (rx_q.size() == 0 && t < 300);
		w = (rx_q.size() != 0) ? rx_q.pop_front() : 32'hxxxx_xxxx;
		chk(what, exp & mask, w & mask);
	endtask

	task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done)
		begin
			@(posedge sys_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			done = (bvalid === 1'b1);
		end
		bready <= 1'b0;
		chk("bresp", {30'h0, r}, {30'h0, bresp});
	endtask

	task axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rdata", d, rdata);
		chk("rresp", {30'h0, r}, {30'h0, rresp});
	endtask

	// The field argument f is laid out exactly as packet bits 13 to 0.
	task run_vec(input logic [1:0] k, input logic [6:0] pos, input logic [1:0] ph,
		input logic [2:0] be, input logic cf, input logic lng, input logic [13:0] f,
		input logic e);
		logic [2:0]  vt;
		logic [6:0]  n;
		logic [6:0]  mpos;
		logic [20:0] info;
		logic [31:0] mask;
		vt = (k == SEC) ? 3'h0 : (k == ALP) ? 3'h5 : (k == HEX) ? 3'h6 : 3'h1;
		@(posedge sys_clk);
		vin <= {k, pos, ph, be, cf, lng, f};
		vec_valid <= 1'b1;
		do
			@(posedge sys_clk);
		while (vec_ready !== 1'b1);
		vec_valid <= 1'b0;
		pop_chk("vector", {1'b0, pos, e, ph, 2'h0, vt, 2'h0, f}, 32'hffff_ffff);
		nv++;
		ne += e;
		n = e ? 7'h00 : (k == INS) ? {6'h00, lng} : f[13:7];
		mask = (k == INS && f[2:0] != vec_pack_pkg::IT_TADDR_SEQ) ? 32'hffe0_0000 : 32'hffff_ffff;
		for (int i = 0; i < n; i++)
		begin
			mpos = (lng && i == 0) ? pos + 7'h01 : f[6:0] + 7'(i) - {6'h00, lng};
			info = {pos, 7'(i), 7'h2a};
			min <= {2'(ph + 2'(i)), 3'(i), info};
			msg_valid <= 1'b1;
			do
				@(posedge sys_clk);
			while (msg_ready !== 1'b1);
			msg_valid <= 1'b0;
			pop_chk("message", {1'b0, mpos, 3'(i) > 3'h2, 2'(ph + 2'(i)), info}, mask);
		end
	endtask

	initial
	begin
		#2000000;
		err_count++;
		test_done;
	end

	initial
	begin
		{sys_clk, slow, vec_valid, msg_valid, vin, min} = '0;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wstrb, wdata} = '0;
		{err_count, compares, nv, ne} = '0;
		rst = 1'b1;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		axi_rd(vec_pack_pkg::CTRL_OFS, 32'h0000_0001, vec_pack_pkg::RESP_OKAY);
		axi_rd(vec_pack_pkg::VEC_CNT_OFS, 32'h0, vec_pack_pkg::RESP_OKAY);
		axi_rd(4'h2, 32'h0, vec_pack_pkg::RESP_DECERR);
		axi_wr(4'h2, 32'h1, 4'hf, vec_pack_pkg::RESP_DECERR);
		run_vec(SEC, 7'h57, 2'h0, 3'h0, 1'b0, 1'b0, {7'h01, 7'h57}, 1'b0);
		run_vec(ALP, 7'h02, 2'h1, 3'h2, 1'b0, 1'b1, {7'h03, 7'h0a}, 1'b0);
		run_vec(HEX, 7'h28, 2'h2, 3'h0, 1'b0, 1'b0, {7'h55, 7'h03}, 1'b0);
		run_vec(ALP, 7'h1e, 2'h3, 3'h3, 1'b0, 1'b0, {7'h02, 7'h0a}, 1'b1);
		run_vec(SEC, 7'h1e, 2'h3, 3'h0, 1'b1, 1'b1, {7'h02, 7'h0a}, 1'b1);
		run_vec(HEX, 7'h58, 2'h0, 3'h0, 1'b0, 1'b0, {7'h02, 7'h0a}, 1'b1);
		run_vec(HEX, 7'h01, 2'h0, 3'h0, 1'b0, 1'b0, {7'h02, 7'h0a}, 1'b1);
		run_vec(ALP, 7'h10, 2'h1, 3'h0, 1'b0, 1'b0, {7'h00, 7'h0a}, 1'b1);
		run_vec(ALP, 7'h10, 2'h1, 3'h0, 1'b0, 1'b0, {7'h56, 7'h0a}, 1'b1);
		run_vec(ALP, 7'h10, 2'h1, 3'h0, 1'b0, 1'b0, {7'h02, 7'h02}, 1'b1);
		run_vec(ALP, 7'h10, 2'h1, 3'h0, 1'b0, 1'b0, {7'h02, 7'h58}, 1'b1);
		axi_rd(vec_pack_pkg::STATUS_OFS, 32'h0000_0010, vec_pack_pkg::RESP_OKAY);
		slow <= 1'b1;
		run_vec(INS, 7'h05, 2'h1, 3'h1, 1'b0, 1'b0, {11'h5a3, 3'h0}, 1'b0);
		run_vec(INS, 7'h06, 2'h2, 3'h0, 1'b0, 1'b1, {11'h2b5, 3'h1}, 1'b0);
		run_vec(INS, 7'h07, 2'h3, 3'h0, 1'b0, 1'b1, {11'h4ed, 3'h2}, 1'b0);
		for (int it = 3; it < 8; it++)
			run_vec(INS, 7'h08, 2'h0, 3'h0, 1'b0, 1'b0, {11'h3c1, 3'(it)}, 1'b0);
		run_vec(INS, 7'h09, 2'h0, 3'h3, 1'b0, 1'b1, {11'h111, 3'h0}, 1'b1);
		run_vec(INS, 7'h0a, 2'h1, 3'h0, 1'b1, 1'b1, {11'h222, 3'h2}, 1'b1);
		run_vec(INS, 7'h64, 2'h2, 3'h2, 1'b0, 1'b0, {11'h333, 3'h1}, 1'b0);
		slow <= 1'b0;
		axi_wr(vec_pack_pkg::CTRL_OFS, 32'h0, 4'he, vec_pack_pkg::RESP_OKAY);
		axi_rd(vec_pack_pkg::CTRL_OFS, 32'h0000_0001, vec_pack_pkg::RESP_OKAY);
		axi_wr(vec_pack_pkg::CTRL_OFS, 32'h0, 4'h1, vec_pack_pkg::RESP_OKAY);
		axi_rd(vec_pack_pkg::CTRL_OFS, 32'h0, vec_pack_pkg::RESP_OKAY);
		vec_valid <= 1'b1;
		repeat (8)
		begin
			@(posedge sys_clk);
			chk("vec_ready while off", 32'h0, {31'h0, vec_ready});
		end
		vec_valid <= 1'b0;
		chk("packets while off", 32'h0, 32'(rx_q.size()));
		axi_wr(vec_pack_pkg::CTRL_OFS, 32'h1, 4'h1, vec_pack_pkg::RESP_OKAY);
		run_vec(ALP, 7'h20, 2'h2, 3'h0, 1'b0, 1'b1, {7'h01, 7'h30}, 1'b0);
		axi_wr(vec_pack_pkg::VEC_CNT_OFS, 32'hffff_ffff, 4'hf, vec_pack_pkg::RESP_OKAY);
		axi_rd(vec_pack_pkg::VEC_CNT_OFS, 32'(nv), vec_pack_pkg::RESP_OKAY);
		axi_rd(vec_pack_pkg::ERR_CNT_OFS, 32'(ne), vec_pack_pkg::RESP_OKAY);
		repeat (20) @(posedge sys_clk);
		chk("stray packets", 32'h0, 32'(rx_q.size()));
		test_done;
	end
endmodule
